// ===== cdm_pkg.sv
// Operation
// - load_bank_literal copies 5-bit literal into bank_select_register; flags untouched.
// - load_pc_latch_literal copies 7-bit literal into pc_high_latch; flags untouched.
// - load_work_literal puts 8-bit literal into work register in one cycle.
// - store_work_to_file writes work register to file addressed by 7-bit operand.
// - load option instruction copies work register into option register; flags untouched.
// - store_work_indirect writes work register through indirect pointer 0 or 1.
// - indirect_window addresses hold nothing; they reach the address in the pointer.
// - pointer_mode_field: 00 preinc, 01 predec, 10 postinc, 11 postdec.
// - pre modes address pointer plus/minus one; post modes use old, then step.
// - relative form addresses pointer plus signed offset -32..31; pointer unchanged.
// - indirect_pointer is 16 bits and wraps modulo 65536 on step.
// - pointer updates and indirect stores change no status flag.
package cdm_pkg;
	// ****************************************
	// widths
	// ****************************************
	localparam int BANK_W = 5;
	localparam int PCL_W = 7;
	localparam int DATA_W = 8;
	localparam int FILE_W = 7;
	localparam int PTR_W = 16;
	localparam int OFS_W = 6;
	localparam int STAT_W = 3;
	localparam int PAD_W = PTR_W - BANK_W - FILE_W;

	// ****************************************
	// file addresses of core registers
	// ****************************************
	localparam logic [FILE_W-1:0] WIN0_ADDR = 7'h00;
	localparam logic [FILE_W-1:0] WIN1_ADDR = 7'h01;
	localparam logic [FILE_W-1:0] PTR0_LO_ADDR = 7'h04;
	localparam logic [FILE_W-1:0] PTR0_HI_ADDR = 7'h05;
	localparam logic [FILE_W-1:0] PTR1_LO_ADDR = 7'h06;
	localparam logic [FILE_W-1:0] PTR1_HI_ADDR = 7'h07;

	// ****************************************
	// pointer mode codes and steps
	// ****************************************
	localparam logic [1:0] PM_PRE_INC = 2'h0;
	localparam logic [1:0] PM_PRE_DEC = 2'h1;
	localparam logic [1:0] PM_POST_INC = 2'h2;
	localparam logic [1:0] PM_POST_DEC = 2'h3;
	localparam logic [PTR_W-1:0] PTR_STEP = 16'h0001;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
	localparam logic [BANK_W-1:0] BANK_RST = 5'h00;
	localparam logic [PCL_W-1:0] PCL_RST = 7'h00;
	localparam logic [DATA_W-1:0] OPTION_RST = 8'hFF;
	localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
	localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;

	typedef enum logic [2:0] {
		CDM_OP_NONE = 3'h0,
		CDM_OP_LOAD_BANK = 3'h1,
		CDM_OP_LOAD_PCL = 3'h2,
		CDM_OP_LOAD_WORK = 3'h3,
		CDM_OP_STORE_FILE = 3'h4,
		CDM_OP_LOAD_OPTION = 3'h5,
		CDM_OP_STORE_IND = 3'h6,
		CDM_OP_STORE_REL = 3'h7
	} cdm_op_t;

	typedef struct packed {
		logic [DATA_W-1:0] work;
		logic [BANK_W-1:0] bank;
		logic [PCL_W-1:0] pcl;
		logic [DATA_W-1:0] option;
		logic [STAT_W-1:0] status;
		logic [PTR_W-1:0] ptr0;
		logic [PTR_W-1:0] ptr1;
		logic mem_we;
		logic [PTR_W-1:0] mem_addr;
		logic [DATA_W-1:0] mem_wdata;
		logic done;
	} cdm_state_t;
endpackage

// ===== cdm_ptr_calc.sv
`timescale 1ns/10ps
module cdm_ptr_calc (
	input wire logic [cdm_pkg::PTR_W-1:0] ptr,
	input wire logic [1:0] pointer_mode_field,
	input wire logic rel,
	input wire logic [cdm_pkg::OFS_W-1:0] rel_offset,
	output logic [cdm_pkg::PTR_W-1:0] eff_addr,
	output logic [cdm_pkg::PTR_W-1:0] ptr_next
);
	logic [cdm_pkg::PTR_W-1:0] inc;
	logic [cdm_pkg::PTR_W-1:0] dec;
	logic [cdm_pkg::PTR_W-1:0] sext;

	// 16-bit sums drop the carry, so both ends wrap
	assign inc = ptr + cdm_pkg::PTR_STEP;
	assign dec = ptr - cdm_pkg::PTR_STEP;
	assign sext = {{(cdm_pkg::PTR_W-cdm_pkg::OFS_W){rel_offset[cdm_pkg::OFS_W-1]}}, rel_offset};

	always_comb begin
		eff_addr = ptr;
		ptr_next = ptr;
		if (rel) begin
			eff_addr = ptr + sext;
		end else begin
			case (pointer_mode_field)
				cdm_pkg::PM_PRE_INC: begin
					eff_addr = inc;
					ptr_next = inc;
				end
				cdm_pkg::PM_PRE_DEC: begin
					eff_addr = dec;
					ptr_next = dec;
				end
				cdm_pkg::PM_POST_INC: begin
					ptr_next = inc;
				end
				default: begin
					ptr_next = dec;
				end
			endcase
		end
	end
endmodule

// ===== cdm_addr_map.sv
`timescale 1ns/10ps
module cdm_addr_map (
	input wire logic [cdm_pkg::BANK_W-1:0] bank,
	input wire logic [cdm_pkg::FILE_W-1:0] file_addr,
	input wire logic [cdm_pkg::PTR_W-1:0] ptr0,
	input wire logic [cdm_pkg::PTR_W-1:0] ptr1,
	output logic [cdm_pkg::PTR_W-1:0] mem_addr
);
	// windows are decoded in every bank, like other core registers
	always_comb begin
		if (file_addr == cdm_pkg::WIN0_ADDR) begin
			mem_addr = ptr0;
		end else if (file_addr == cdm_pkg::WIN1_ADDR) begin
			mem_addr = ptr1;
		end else begin
			mem_addr = {{cdm_pkg::PAD_W{1'b0}}, bank, file_addr};
		end
	end
endmodule

// ===== cdm_core.sv
`timescale 1ns/10ps
module cdm_core (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic instr_valid,
	input cdm_pkg::cdm_op_t op,
	input wire logic [cdm_pkg::DATA_W-1:0] lit,
	input wire logic [cdm_pkg::FILE_W-1:0] file_addr,
	input wire logic ptr_sel,
	input wire logic [1:0] pointer_mode_field,
	input wire logic [cdm_pkg::OFS_W-1:0] rel_offset,
	input wire logic status_load,
	input wire logic [cdm_pkg::STAT_W-1:0] status_din,
	output logic [cdm_pkg::DATA_W-1:0] work_reg,
	output logic [cdm_pkg::BANK_W-1:0] bank_select_register,
	output logic [cdm_pkg::PCL_W-1:0] pc_high_latch,
	output logic [cdm_pkg::DATA_W-1:0] option_reg,
	output logic [cdm_pkg::STAT_W-1:0] status_flags,
	output logic [cdm_pkg::PTR_W-1:0] indirect_pointer0,
	output logic [cdm_pkg::PTR_W-1:0] indirect_pointer1,
	output logic mem_we,
	output logic [cdm_pkg::PTR_W-1:0] mem_addr,
	output logic [cdm_pkg::DATA_W-1:0] mem_wdata,
	output logic instr_done
);
	// ****************************************
	// state and helpers
	// ****************************************
	cdm_pkg::cdm_state_t s_r;
	cdm_pkg::cdm_state_t s_nxt;
	logic [cdm_pkg::PTR_W-1:0] sel_ptr;
	logic [cdm_pkg::PTR_W-1:0] ind_addr;
	logic [cdm_pkg::PTR_W-1:0] ind_next;
	logic [cdm_pkg::PTR_W-1:0] dir_addr;
	logic is_rel;

	assign sel_ptr = ptr_sel ? s_r.ptr1 : s_r.ptr0;
	assign is_rel = (op == cdm_pkg::CDM_OP_STORE_REL);

	// ****************************************
	// address units
	// ****************************************
	cdm_ptr_calc u_ptr_calc (
		.ptr(sel_ptr),
		.pointer_mode_field(pointer_mode_field),
		.rel(is_rel),
		.rel_offset(rel_offset),
		.eff_addr(ind_addr),
		.ptr_next(ind_next)
	);

	cdm_addr_map u_addr_map (
		.bank(s_r.bank),
		.file_addr(file_addr),
		.ptr0(s_r.ptr0),
		.ptr1(s_r.ptr1),
		.mem_addr(dir_addr)
	);

	// ****************************************
	// execute
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.mem_we = 1'b0;
		s_nxt.done = 1'b0;
		if (instr_valid) begin
			s_nxt.done = 1'b1;
			case (op)
				cdm_pkg::CDM_OP_LOAD_BANK: begin
					s_nxt.bank = lit[cdm_pkg::BANK_W-1:0];
				end
				cdm_pkg::CDM_OP_LOAD_PCL: begin
					s_nxt.pcl = lit[cdm_pkg::PCL_W-1:0];
				end
				cdm_pkg::CDM_OP_LOAD_WORK: begin
					s_nxt.work = lit;
				end
				cdm_pkg::CDM_OP_STORE_FILE: begin
					// pointer bytes live in the core, not in data memory
					case (file_addr)
						cdm_pkg::PTR0_LO_ADDR: begin
							s_nxt.ptr0[7:0] = s_r.work;
						end
						cdm_pkg::PTR0_HI_ADDR: begin
							s_nxt.ptr0[15:8] = s_r.work;
						end
						cdm_pkg::PTR1_LO_ADDR: begin
							s_nxt.ptr1[7:0] = s_r.work;
						end
						cdm_pkg::PTR1_HI_ADDR: begin
							s_nxt.ptr1[15:8] = s_r.work;
						end
						default: begin
							s_nxt.mem_we = 1'b1;
							s_nxt.mem_addr = dir_addr;
							s_nxt.mem_wdata = s_r.work;
						end
					endcase
				end
				cdm_pkg::CDM_OP_LOAD_OPTION: begin
					s_nxt.option = s_r.work;
				end
				cdm_pkg::CDM_OP_STORE_IND, cdm_pkg::CDM_OP_STORE_REL: begin
					s_nxt.mem_we = 1'b1;
					s_nxt.mem_addr = ind_addr;
					s_nxt.mem_wdata = s_r.work;
					if (ptr_sel) begin
						s_nxt.ptr1 = ind_next;
					end else begin
						s_nxt.ptr0 = ind_next;
					end
				end
				default: begin
					s_nxt.done = 1'b0;
				end
			endcase
		end
		// flags move only by the outside load; no move here touches them
		if (status_load) begin
			s_nxt.status = status_din;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r.work <= cdm_pkg::WORK_RST;
			s_r.bank <= cdm_pkg::BANK_RST;
			s_r.pcl <= cdm_pkg::PCL_RST;
			s_r.option <= cdm_pkg::OPTION_RST;
			s_r.status <= cdm_pkg::STAT_RST;
			s_r.ptr0 <= cdm_pkg::PTR_RST;
			s_r.ptr1 <= cdm_pkg::PTR_RST;
			s_r.mem_we <= 1'b0;
			s_r.mem_addr <= cdm_pkg::PTR_RST;
			s_r.mem_wdata <= cdm_pkg::WORK_RST;
			s_r.done <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign work_reg = s_r.work;
	assign bank_select_register = s_r.bank;
	assign pc_high_latch = s_r.pcl;
	assign option_reg = s_r.option;
	assign status_flags = s_r.status;
	assign indirect_pointer0 = s_r.ptr0;
	assign indirect_pointer1 = s_r.ptr1;
	assign mem_we = s_r.mem_we;
	assign mem_addr = s_r.mem_addr;
	assign mem_wdata = s_r.mem_wdata;
	assign instr_done = s_r.done;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	logic is_win;
	logic is_preg;
	assign is_win = (file_addr == cdm_pkg::WIN0_ADDR) || (file_addr == cdm_pkg::WIN1_ADDR);
	assign is_preg = (file_addr[6:2] == cdm_pkg::PTR0_LO_ADDR[6:2]);

	chk_bank_load: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_LOAD_BANK && !status_load
		|=> bank_select_register == $past(lit[4:0]) && $stable(status_flags) && !mem_we)
		else $error("bank literal not loaded");

	chk_pcl_load: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_LOAD_PCL
		|=> pc_high_latch == $past(lit[6:0]) && $stable(work_reg))
		else $error("pc latch literal not loaded");

	chk_work_load: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_LOAD_WORK
		|=> work_reg == $past(lit) && instr_done)
		else $error("work literal not loaded in one cycle");

	chk_file_store: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_FILE && !is_win && !is_preg
		|=> mem_we && mem_wdata == $past(work_reg)
		&& mem_addr == {4'h0, $past(bank_select_register), $past(file_addr)})
		else $error("direct store wrong");

	chk_option_load: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_LOAD_OPTION
		|=> option_reg == $past(work_reg) && !mem_we)
		else $error("option not loaded from work");

	chk_window_redir: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_FILE && file_addr == cdm_pkg::WIN1_ADDR
		|=> mem_we && mem_addr == $past(indirect_pointer1))
		else $error("window store not redirected");

	chk_pre_inc: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_IND && !ptr_sel && pointer_mode_field == 2'h0
		|=> mem_addr == 16'($past(indirect_pointer0) + 16'h0001) && indirect_pointer0 == mem_addr)
		else $error("preincrement wrong");

	chk_post_dec: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_IND && ptr_sel && pointer_mode_field == 2'h3
		|=> mem_addr == $past(indirect_pointer1)
		&& indirect_pointer1 == 16'($past(indirect_pointer1) - 16'h0001)
		&& $stable(indirect_pointer0))
		else $error("postdecrement wrong");

	chk_rel_keep: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_REL && !ptr_sel
		|=> $stable(indirect_pointer0)
		&& mem_addr == 16'(indirect_pointer0 + {{10{$past(rel_offset[5])}}, $past(rel_offset)}))
		else $error("relative store wrong");

	chk_ptr_wrap: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_IND && !ptr_sel
		&& pointer_mode_field == 2'h2 && indirect_pointer0 == 16'hFFFF
		|=> indirect_pointer0 == 16'h0000 && mem_addr == 16'hFFFF)
		else $error("pointer did not wrap");

	chk_flags_hold: assert property (
		!status_load |=> $stable(status_flags))
		else $error("flags changed by a move");

	chk_done_pulse: assert property (
		instr_valid && op != cdm_pkg::CDM_OP_NONE
		|=> instr_done)
		else $error("done pulse missing");

	chk_none_idle: assert property (
		!instr_valid || op == cdm_pkg::CDM_OP_NONE
		|=> !instr_done && !mem_we)
		else $error("idle cycle had an effect");

	chk_bank_only: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_LOAD_BANK
		|=> $stable(pc_high_latch) && $stable(option_reg) && $stable(work_reg))
		else $error("bank load touched other registers");

	chk_pcl_flags: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_LOAD_PCL && !status_load
		|=> $stable(status_flags) && !mem_we)
		else $error("pc latch load touched flags");

	chk_work_flags: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_LOAD_WORK && !status_load
		|=> $stable(status_flags) && !mem_we)
		else $error("work load touched flags");

	chk_option_flags: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_LOAD_OPTION && !status_load
		|=> $stable(status_flags) && $stable(work_reg))
		else $error("option load touched flags");

	chk_ptr_byte_lo: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_FILE && file_addr == cdm_pkg::PTR0_LO_ADDR
		|=> !mem_we && indirect_pointer0[7:0] == $past(work_reg))
		else $error("pointer low byte not written");

	chk_ptr_byte_hi: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_FILE && file_addr == cdm_pkg::PTR0_HI_ADDR
		|=> !mem_we && indirect_pointer0[15:8] == $past(work_reg))
		else $error("pointer high byte not written");

	chk_window0_redir: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_FILE && file_addr == cdm_pkg::WIN0_ADDR
		|=> mem_we && mem_addr == $past(indirect_pointer0) && $stable(indirect_pointer0))
		else $error("window zero store not redirected");

	chk_pre_dec: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_IND && ptr_sel && pointer_mode_field == 2'h1
		|=> mem_addr == 16'($past(indirect_pointer1) - 16'h0001) && indirect_pointer1 == mem_addr)
		else $error("predecrement wrong");

	chk_post_inc: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_IND && !ptr_sel && pointer_mode_field == 2'h2
		|=> mem_addr == $past(indirect_pointer0) && $stable(indirect_pointer1)
		&& indirect_pointer0 == 16'($past(indirect_pointer0) + 16'h0001))
		else $error("postincrement wrong");

	chk_ind_data: assert property (
		instr_valid && (op == cdm_pkg::CDM_OP_STORE_IND || op == cdm_pkg::CDM_OP_STORE_REL)
		|=> mem_we && mem_wdata == $past(work_reg))
		else $error("indirect store data wrong");

	chk_rel_ptr1: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_REL && ptr_sel
		|=> $stable(indirect_pointer1) && $stable(indirect_pointer0))
		else $error("relative store moved a pointer");

	chk_dec_wrap: assert property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_IND && ptr_sel && pointer_mode_field == 2'h1
		&& indirect_pointer1 == 16'h0000 |=> indirect_pointer1 == 16'hFFFF && mem_addr == 16'hFFFF)
		else $error("pointer did not wrap below zero");

	cov_pre_dec: cover property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_IND && pointer_mode_field == 2'h1 ##1 mem_we);
	cov_rel_neg: cover property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_REL && rel_offset[5] ##1 mem_we);
	cov_win_store: cover property (
		instr_valid && op == cdm_pkg::CDM_OP_STORE_FILE && file_addr == cdm_pkg::WIN0_ADDR);
	cov_back_to_back: cover property (mem_we [*3]);
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
	// ****************************************
	// stimulus and expected state
	// ****************************************
	localparam cdm_pkg::cdm_op_t LW = cdm_pkg::CDM_OP_LOAD_WORK;
	localparam cdm_pkg::cdm_op_t SF = cdm_pkg::CDM_OP_STORE_FILE;
	localparam cdm_pkg::cdm_op_t SI = cdm_pkg::CDM_OP_STORE_IND;
	localparam cdm_pkg::cdm_op_t SR = cdm_pkg::CDM_OP_STORE_REL;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic instr_valid = 1'b0;
	cdm_pkg::cdm_op_t op = cdm_pkg::CDM_OP_NONE;
	logic [7:0] lit = 8'h00;
	logic [6:0] file_addr = 7'h00;
	logic ptr_sel = 1'b0;
	logic [1:0] pointer_mode_field = 2'h0;
	logic [5:0] rel_offset = 6'h00;
	logic status_load = 1'b0;
	logic [2:0] status_din = 3'h0;
	logic [7:0] work_reg, option_reg, mem_wdata, e_work, e_option, e_wdata;
	logic [4:0] bank_select_register, e_bank;
	logic [6:0] pc_high_latch, e_pcl;
	logic [2:0] status_flags, e_stat;
	logic [15:0] indirect_pointer0, indirect_pointer1, mem_addr, e_addr;
	logic [15:0] e_ptr [2];
	logic mem_we, instr_done, e_we, e_done;
	int n_errors = 0;
	int check_count = 0;

	always #25 clk = ~clk;

	cdm_core i_dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .op(op), .lit(lit),
		.file_addr(file_addr), .ptr_sel(ptr_sel), .pointer_mode_field(pointer_mode_field),
		.rel_offset(rel_offset), .status_load(status_load), .status_din(status_din),
		.work_reg(work_reg), .bank_select_register(bank_select_register), .pc_high_latch(pc_high_latch),
		.option_reg(option_reg), .status_flags(status_flags), .indirect_pointer0(indirect_pointer0),
		.indirect_pointer1(indirect_pointer1), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .instr_done(instr_done));

	// ****************************************
	// checking and reference model
	// ****************************************
	task automatic cmp(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic compare_all();
		cmp("work", work_reg, e_work);
		cmp("bank", bank_select_register, e_bank);
		cmp("pcl", pc_high_latch, e_pcl);
		cmp("option", option_reg, e_option);
		cmp("status", status_flags, e_stat);
		cmp("ptr0", indirect_pointer0, e_ptr[0]);
		cmp("ptr1", indirect_pointer1, e_ptr[1]);
		cmp("we", mem_we, e_we);
		cmp("addr", mem_addr, e_addr);
		cmp("wdata", mem_wdata, e_wdata);
		cmp("done", instr_done, e_done);
	endtask

	task automatic wr(input logic [15:0] a);
		e_we = 1'b1;
		e_addr = a;
		e_wdata = e_work;
	endtask

	task automatic model(input logic v, input cdm_pkg::cdm_op_t o, input logic [7:0] k, input logic [6:0] f,
		input logic s, input logic [1:0] m, input logic [5:0] r, input logic sl, input logic [2:0] sd);
		logic [15:0] p;
		logic [15:0] nx;
		p = e_ptr[s];
		nx = m[0] ? p - 16'h0001 : p + 16'h0001;
		e_we = 1'b0;
		e_done = v && (o != cdm_pkg::CDM_OP_NONE);
		if (sl) begin
			e_stat = sd;
		end
		if (v) begin
			case (o)
				cdm_pkg::CDM_OP_LOAD_BANK: e_bank = k[4:0];
				cdm_pkg::CDM_OP_LOAD_PCL: e_pcl = k[6:0];
				LW: e_work = k;
				cdm_pkg::CDM_OP_LOAD_OPTION: e_option = e_work;
				SF: begin
					// pointer bytes live in the core, never on the memory port
					if (f[6:2] == 5'h01 && f[0]) e_ptr[f[1]][15:8] = e_work;
					else if (f[6:2] == 5'h01) e_ptr[f[1]][7:0] = e_work;
					else if (f[6:1] == 6'h00) wr(e_ptr[f[0]]);
					else wr({4'h0, e_bank, f});
				end
				SI: begin
					wr(m[1] ? p : nx);
					e_ptr[s] = nx;
				end
				SR: wr(p + {{10{r[5]}}, r});
				default: ;
			endcase
		end
	endtask

	// results of an instruction show one edge later, so each step checks its predecessor
	task automatic step(input logic v, input cdm_pkg::cdm_op_t o, input logic [7:0] k, input logic [6:0] f,
		input logic s, input logic [1:0] m, input logic [5:0] r, input logic sl, input logic [2:0] sd);
		@(posedge clk);
		instr_valid <= v;
		op <= o;
		lit <= k;
		file_addr <= f;
		ptr_sel <= s;
		pointer_mode_field <= m;
		rel_offset <= r;
		status_load <= sl;
		status_din <= sd;
		@(negedge clk);
		compare_all();
		model(v, o, k, f, s, m, r, sl, sd);
	endtask

	task automatic ins(input cdm_pkg::cdm_op_t o, input logic [7:0] k, input logic [6:0] f, input logic s,
		input logic [1:0] m, input logic [5:0] r);
		step(1'b1, o, k, f, s, m, r, 1'b0, 3'h0);
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		instr_valid <= 1'b0;
		status_load <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		e_work = cdm_pkg::WORK_RST;
		e_bank = cdm_pkg::BANK_RST;
		e_pcl = cdm_pkg::PCL_RST;
		e_option = cdm_pkg::OPTION_RST;
		e_stat = cdm_pkg::STAT_RST;
		e_ptr[0] = cdm_pkg::PTR_RST;
		e_ptr[1] = cdm_pkg::PTR_RST;
		e_addr = 16'h0000;
		e_wdata = 8'h00;
		e_we = 1'b0;
		e_done = 1'b0;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		void'($urandom(62));
		do_reset();
		ins(LW, 8'hFF, 7'h00, 1'b0, 2'h0, 6'h00);
		ins(SF, 8'h00, 7'h04, 1'b0, 2'h0, 6'h00);
		ins(SF, 8'h00, 7'h05, 1'b0, 2'h0, 6'h00);
		ins(SI, 8'h00, 7'h00, 1'b0, 2'h0, 6'h00);
		ins(SI, 8'h00, 7'h00, 1'b1, 2'h1, 6'h00);
		ins(SI, 8'h00, 7'h00, 1'b0, 2'h1, 6'h00);
		ins(SI, 8'h00, 7'h00, 1'b0, 2'h2, 6'h00);
		for (int i = 0; i < 8; i++) begin
			ins(LW, 8'($urandom), 7'h00, 1'b0, 2'h0, 6'h00);
			ins(SI, 8'h00, 7'h00, i[0], i[2:1], 6'h00);
			ins(SR, 8'h00, 7'h00, i[0], 2'h0, i[1] ? 6'h20 : 6'h1F);
			ins(SF, 8'h00, {6'h00, i[0]}, 1'b0, 2'h0, 6'h00);
		end
		ins(cdm_pkg::CDM_OP_LOAD_BANK, 8'hFF, 7'h00, 1'b0, 2'h0, 6'h00);
		ins(SF, 8'h00, 7'h7F, 1'b0, 2'h0, 6'h00);
		ins(cdm_pkg::CDM_OP_LOAD_PCL, 8'hFF, 7'h00, 1'b0, 2'h0, 6'h00);
		ins(cdm_pkg::CDM_OP_LOAD_OPTION, 8'h00, 7'h00, 1'b0, 2'h0, 6'h00);
		for (int i = 0; i < 500; i++) begin
			if (i == 250) do_reset();
			step(($urandom % 8) != 0, cdm_pkg::cdm_op_t'($urandom_range(0, 7)), 8'($urandom), 7'($urandom),
				1'($urandom), 2'($urandom), 6'($urandom), ($urandom % 4) == 0, 3'($urandom));
		end
		step(1'b0, cdm_pkg::CDM_OP_NONE, 8'h00, 7'h00, 1'b0, 2'h0, 6'h00, 1'b0, 3'h0);
		conclude();
	end

	initial begin
		#(50 * 5000);
		n_errors++;
		conclude();
	end
endmodule
